// ===== plwd_defines.svh
// Purpose: Constants for the program loop watchdog
// Assumes: Byte-wide CPU register port, 16-bit addresses
// Notes: Definitions only
`ifndef PLWD_DEFINES_SVH
`define PLWD_DEFINES_SVH

// ---------------------------------------------
// Register map
// ---------------------------------------------
`define PLWD_ADDR_MODE 16'hff48
`define PLWD_ADDR_RESTART 16'hff49
`define PLWD_MODE_RESET 8'h67
`define PLWD_RESTART_READ 8'h9a
`define PLWD_RESTART_KEY 8'hac
`define PLWD_MODE_FIXED_HI 3'h3

// ---------------------------------------------
// Mode field layout
// ---------------------------------------------
`define PLWD_CS_HI 4
`define PLWD_CS_LO 3
`define PLWD_INT_HI 2
`define PLWD_INT_LO 0
`define PLWD_CAUSE_BIT 4

// ---------------------------------------------
// Counter
// ---------------------------------------------
`define PLWD_CNT_W 21
`define PLWD_EXP_LOW 5'hb
`define PLWD_EXP_SYS 5'hd

`endif

// ===== plwd_pkg.sv
// Purpose: Types for the program loop watchdog
// Assumes: Nothing beyond the defines header
// Notes: Mode register write allowance states
`default_nettype none

package plwd_pkg;
  typedef enum logic [1:0]
  {
    PLWD_W_OPEN = 2'b00,
    PLWD_W_LOCKED = 2'b01,
    PLWD_W_STOPPED = 2'b10
  } plwd_wstate_t;
endpackage

`default_nettype wire

// ===== plwd_program_loop_watchdog.sv
// Purpose: Program loop watchdog with write-once mode and keyed restart
// Assumes: Clock-domain tick enables from the clock generator
// Notes: nrst_i is the power-on reset; chip_reset_o resets the chip
`default_nettype none
`include "plwd_defines.svh"

// Behaviour
// - Overflow at selected interval raises chip reset
// - Watchdog reset sets reset cause bit four
// - Low-speed source interval is 2^(11+n) ticks
// - System source interval is 2^(13+n) ticks
// - Clock select: 00 low, 01 system, 1x stop
// - Mode loads 67h at every reset
// - Unstoppable option forces low-speed, never stopped
// - One mode write; later write forces reset
// - Stopped watchdog suppresses all misuse resets
// - Reads have no side effects
// - Restart key ACh clears the counter
// - Other restart values force chip reset
// - Bit access to restart forces chip reset
// - Restart register always reads 9Ah
// - System source gated by stop, halt, stabilisation
// - Low source gated by halt, stop, oscillator-off while CPU runs on system clock
// - Power-up option picks unstoppable or stoppable mode
// - Accepted mode write clears the counter
// - Counter holds its value across halt/stop, except with the unstoppable option
module plwd_program_loop_watchdog
(
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic bitop_i,
  input wire logic [7:0] wdata_i,
  input wire logic osc_unstoppable_i,
  input wire logic low_speed_tick_i,
  input wire logic system_tick_i,
  input wire logic halt_i,
  input wire logic stop_i,
  input wire logic sysclk_stopped_i,
  input wire logic osc_stab_i,
  input wire logic cpu_on_sysclk_i,
  input wire logic low_speed_osc_off_i,
  input wire logic cause_clr_i,
  output logic [7:0] rdata_o,
  output logic chip_reset_o,
  output logic [7:0] reset_cause_o
);

  // ---------------------------------------------
  // Declarations
  // ---------------------------------------------
  logic [7:0] mode_ff;
  logic [7:0] nxt_mode;
  plwd_pkg::plwd_wstate_t wstate_ff;
  plwd_pkg::plwd_wstate_t nxt_wstate;
  logic [`PLWD_CNT_W-1:0] cnt_ff;
  logic opt_valid_ff;
  logic opt_ff;
  logic unstop;
  logic src_sys;
  logic tick_en;
  logic mode_wr;
  logic restart_wr;
  logic restart_ok;
  logic mode_accept;
  logic misuse;
  logic overflow;
  logic fire;

  function automatic logic [`PLWD_CNT_W-1:0] plwd_last(input logic sys, input logic [2:0] n);
    logic [4:0] e;
    logic [`PLWD_CNT_W-1:0] one;
    e = (sys ? `PLWD_EXP_SYS : `PLWD_EXP_LOW) + {2'h0, n};
    one = {{(`PLWD_CNT_W-1){1'b0}}, 1'b1};
    plwd_last = (one << e) - one;
  endfunction
  // ---------------------------------------------
  // Power-up option capture
  // ---------------------------------------------
  // Caught after release, not under reset, and re-caught after our own reset
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      opt_valid_ff <= 1'b0;
      opt_ff <= 1'b0;
    end
    else if (fire)
    begin
      opt_valid_ff <= 1'b0;
    end
    else if (!opt_valid_ff)
    begin
      opt_valid_ff <= 1'b1;
      opt_ff <= osc_unstoppable_i;
    end
  end

  assign unstop = opt_valid_ff ? opt_ff : osc_unstoppable_i;

  // ---------------------------------------------
  // Access decode
  // ---------------------------------------------
  assign mode_wr = wr_i && (addr_i == `PLWD_ADDR_MODE);
  assign restart_wr = wr_i && (addr_i == `PLWD_ADDR_RESTART);
  assign restart_ok = restart_wr && !bitop_i && (wdata_i == `PLWD_RESTART_KEY);
  // Bit writes to the mode register are not a valid store: dropped while open, chip reset once locked
  assign mode_accept = mode_wr && !bitop_i && (wstate_ff == plwd_pkg::PLWD_W_OPEN);

  always_comb
  begin
    misuse = 1'b0;
    if (wstate_ff != plwd_pkg::PLWD_W_STOPPED)
    begin
      if (mode_wr && (wstate_ff == plwd_pkg::PLWD_W_LOCKED))
      begin
        misuse = 1'b1;
      end
      if (restart_wr && !restart_ok)
      begin
        misuse = 1'b1;
      end
    end
  end

  // ---------------------------------------------
  // Mode register and write allowance
  // ---------------------------------------------
  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_wstate = wstate_ff;
    if (mode_accept)
    begin
      nxt_mode = wdata_i;
      nxt_mode[7:5] = `PLWD_MODE_FIXED_HI;
      if (unstop)
      begin
        nxt_mode[`PLWD_CS_HI:`PLWD_CS_LO] = 2'h0;
      end
      if (nxt_mode[`PLWD_CS_HI])
      begin
        nxt_wstate = plwd_pkg::PLWD_W_STOPPED;
      end
      else
      begin
        nxt_wstate = plwd_pkg::PLWD_W_LOCKED;
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mode_ff <= `PLWD_MODE_RESET;
      wstate_ff <= plwd_pkg::PLWD_W_OPEN;
    end
    else if (fire)
    begin
      mode_ff <= `PLWD_MODE_RESET;
      wstate_ff <= plwd_pkg::PLWD_W_OPEN;
    end
    else
    begin
      mode_ff <= nxt_mode;
      wstate_ff <= nxt_wstate;
    end
  end

  // ---------------------------------------------
  // Count enable and overflow
  // ---------------------------------------------
  assign src_sys = mode_ff[`PLWD_CS_LO] && !unstop;

  always_comb
  begin
    tick_en = 1'b0;
    if (unstop)
    begin
      // Low-speed oscillator cannot be halted, so neither can counting
      tick_en = low_speed_tick_i;
    end
    else if (mode_ff[`PLWD_CS_HI])
    begin
      tick_en = 1'b0;
    end
    else if (src_sys)
    begin
      tick_en = system_tick_i && !sysclk_stopped_i && !halt_i && !stop_i && !osc_stab_i;
    end
    else
    begin
      tick_en = low_speed_tick_i && !halt_i && !stop_i && !(cpu_on_sysclk_i && low_speed_osc_off_i);
    end
  end

  assign overflow = tick_en && !restart_ok && !mode_accept
    && (cnt_ff == plwd_last(src_sys, mode_ff[`PLWD_INT_HI:`PLWD_INT_LO]));
  assign fire = overflow || misuse;

  // ---------------------------------------------
  // Counter
  // ---------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_ff <= '0;
    end
    else if (fire || mode_accept || restart_ok)
    begin
      cnt_ff <= '0;
    end
    else if (tick_en)
    begin
      cnt_ff <= cnt_ff + {{(`PLWD_CNT_W-1){1'b0}}, 1'b1};
    end
    // Gated ticks leave the count alone across halt and stop
  end

  // ---------------------------------------------
  // Reset request and cause flag
  // ---------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      chip_reset_o <= 1'b0;
    end
    else
    begin
      chip_reset_o <= fire;
    end
  end

  // Held on power-on reset only, so it survives the reset it reports
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      reset_cause_o <= 8'h00;
    end
    else if (fire)
    begin
      reset_cause_o[`PLWD_CAUSE_BIT] <= 1'b1;
    end
    else if (cause_clr_i)
    begin
      reset_cause_o[`PLWD_CAUSE_BIT] <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Read path
  // ---------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata_o <= 8'h00;
    end
    else if (rd_i)
    begin
      if (addr_i == `PLWD_ADDR_MODE)
      begin
        rdata_o <= mode_ff;
      end
      else if (addr_i == `PLWD_ADDR_RESTART)
      begin
        rdata_o <= `PLWD_RESTART_READ;
      end
      else
      begin
        rdata_o <= 8'h00;
      end
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  property p_overflow;
    @(posedge clock_i) disable iff (!nrst_i)
    overflow |=> chip_reset_o;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow did not reset");

  property p_cause;
    @(posedge clock_i) disable iff (!nrst_i)
    chip_reset_o |-> reset_cause_o[`PLWD_CAUSE_BIT];
  endproperty
  a_cause: assert property (p_cause) else $error("cause flag missing");

  property p_low_interval;
    @(posedge clock_i) disable iff (!nrst_i)
    (tick_en && !src_sys && !mode_ff[`PLWD_CS_HI] && !fire && !mode_accept && !restart_ok && cnt_ff == 21'h7fe
      && mode_ff[2:0] == 3'h0) |=> (cnt_ff == 21'h7ff);
  endproperty
  a_low_interval: assert property (p_low_interval) else $error("low interval count wrong");

  property p_sys_interval;
    @(posedge clock_i) disable iff (!nrst_i)
    (tick_en && src_sys && cnt_ff == 21'h1fff && mode_ff[2:0] == 3'h0 && !misuse && !restart_ok) |=> chip_reset_o;
  endproperty
  a_sys_interval: assert property (p_sys_interval) else $error("system interval wrong");

  property p_reload;
    @(posedge clock_i) disable iff (!nrst_i)
    chip_reset_o |-> (mode_ff == `PLWD_MODE_RESET) && (wstate_ff == plwd_pkg::PLWD_W_OPEN) && (cnt_ff == '0);
  endproperty
  a_reload: assert property (p_reload) else $error("reset did not re-arm");

  property p_unstop;
    @(posedge clock_i) disable iff (!nrst_i)
    (opt_valid_ff && opt_ff) |-> (mode_ff[`PLWD_CS_HI:`PLWD_CS_LO] == 2'h0) && (wstate_ff != plwd_pkg::PLWD_W_STOPPED);
  endproperty
  a_unstop: assert property (p_unstop) else $error("unstoppable mode stopped");

  property p_second_write;
    @(posedge clock_i) disable iff (!nrst_i)
    (mode_wr && wstate_ff == plwd_pkg::PLWD_W_LOCKED) |=> chip_reset_o ##1 !chip_reset_o;
  endproperty
  a_second_write: assert property (p_second_write) else $error("second mode write not punished");

  property p_stopped_quiet;
    @(posedge clock_i) disable iff (!nrst_i)
    (wstate_ff == plwd_pkg::PLWD_W_STOPPED) |=> !chip_reset_o;
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet) else $error("stopped watchdog reset");

  property p_bad_restart;
    @(posedge clock_i) disable iff (!nrst_i)
    (restart_wr && (bitop_i || wdata_i != `PLWD_RESTART_KEY) && wstate_ff != plwd_pkg::PLWD_W_STOPPED)
      |=> chip_reset_o;
  endproperty
  a_bad_restart: assert property (p_bad_restart) else $error("bad restart not punished");

  property p_restart_clear;
    @(posedge clock_i) disable iff (!nrst_i)
    (restart_ok || mode_accept) |=> (cnt_ff == '0) && !chip_reset_o;
  endproperty
  a_restart_clear: assert property (p_restart_clear) else $error("counter not cleared");

  property p_read_restart;
    @(posedge clock_i) disable iff (!nrst_i)
    (rd_i && addr_i == `PLWD_ADDR_RESTART) |=> (rdata_o == `PLWD_RESTART_READ);
  endproperty
  a_read_restart: assert property (p_read_restart) else $error("restart read value wrong");

  property p_hold;
    @(posedge clock_i) disable iff (!nrst_i)
    (halt_i && !unstop && !wr_i) |=> $stable(cnt_ff);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved in halt");

  property p_read_side;
    @(posedge clock_i) disable iff (!nrst_i)
    (rd_i && !wr_i && !tick_en) |=> $stable(wstate_ff) && $stable(cnt_ff);
  endproperty
  a_read_side: assert property (p_read_side) else $error("read changed state");
endmodule

`default_nettype wire

// ===== program_loop_watchdog_tb_top.sv
// Purpose: Self-checking bench for the program loop watchdog
// Assumes: Tick enables high except in drop windows, so one count per clock
// Notes: Every reset pulse is expected on one exact cycle
`default_nettype none
`include "plwd_defines.svh"

module program_loop_watchdog_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [15:0] addr_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic bitop_i = 1'b0;
  logic [7:0] wdata_i = 8'h00;
  logic opt = 1'b0;
  logic [5:0] gate = 6'h00;
  logic [1:0] tick_off = 2'h0;
  logic cause_clr_i = 1'b0;
  logic [7:0] rdata_o;
  logic chip_reset_o;
  logic [7:0] reset_cause_o;
  logic [31:0] r;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 80;
  logic [7:0] rd_q[$];
  int rst_q[$];

  always #4 clock_i = ~clock_i;

  always @(posedge clock_i)
    cyc <= cyc + 1;

  // Gate order: halt, stop, sysclk stopped, stabilising, cpu on sysclk, osc off
  plwd_program_loop_watchdog dut
  (
    .clock_i(clock_i),
    .nrst_i(nrst_i),
    .addr_i(addr_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .bitop_i(bitop_i),
    .wdata_i(wdata_i),
    .osc_unstoppable_i(opt),
    .low_speed_tick_i(~tick_off[0]),
    .system_tick_i(~tick_off[1]),
    .halt_i(gate[0]),
    .stop_i(gate[1]),
    .sysclk_stopped_i(gate[2]),
    .osc_stab_i(gate[3]),
    .cpu_on_sysclk_i(gate[4]),
    .low_speed_osc_off_i(gate[5]),
    .cause_clr_i(cause_clr_i),
    .rdata_o(rdata_o),
    .chip_reset_o(chip_reset_o),
    .reset_cause_o(reset_cause_o)
  );

  // ---------------------------------------------
  // Checking
  // ---------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_of_test;
    if (failures == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Any pulse without a pending note is a spurious chip reset
  always @(posedge clock_i)
  begin : mon
    logic rd_s;
    rd_s = rd_i;
    #1;
    if (rd_s)
      chk("rdata_o", rd_q.size() ? rd_q.pop_front() : 8'hxx, rdata_o);
    if (chip_reset_o === 1'b1)
    begin
      if (rst_q.size() == 0)
        chk("unexpected chip_reset_o", 0, 1);
      else
        chk("chip_reset_o cycle", rst_q.pop_front(), cyc);
      chk("reset_cause_o", 8'h10, reset_cause_o);
    end
  end

  // ---------------------------------------------
  // Driving
  // ---------------------------------------------
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w, input logic b, input logic [7:0] e);
    addr_i = a;
    wdata_i = d;
    wr_i = w;
    rd_i = ~w;
    bitop_i = b;
    if (!w)
      rd_q.push_back(e);
    @(negedge clock_i);
    wr_i = 1'b0;
    rd_i = 1'b0;
    bitop_i = 1'b0;
    @(negedge clock_i);
  endtask

  task automatic hold(input logic [5:0] g, input int n);
    gate = g;
    repeat (n) @(negedge clock_i);
    gate = 6'h00;
    @(negedge clock_i);
  endtask

  // Withholds tick enables: bit 0 low-speed, bit 1 system
  task automatic drop(input logic [1:0] t, input int n);
    tick_off = t;
    repeat (n) @(negedge clock_i);
    tick_off = 2'h0;
    @(negedge clock_i);
  endtask

  task automatic do_reset(input logic o);
    nrst_i = 1'b0;
    opt = o;
    repeat (8) @(negedge clock_i);
    nrst_i = 1'b1;
    @(negedge clock_i);
  endtask

  // Bounded wait for every pending reset note to be consumed
  task automatic wait_rst;
    repeat (12000)
      if (rst_q.size() != 0)
        @(negedge clock_i);
    if (rst_q.size() != 0)
      chk("missed chip_reset_o", 0, rst_q.size());
    rst_q.delete();
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  initial
  begin
    @(negedge clock_i);
    do_reset(1'b0);
    acc(`PLWD_ADDR_MODE, 8'h70, 1'b1, 1'b1, 8'h00);
    acc(`PLWD_ADDR_MODE, 8'h00, 1'b0, 1'b0, 8'h67);
    acc(`PLWD_ADDR_RESTART, 8'h00, 1'b0, 1'b0, 8'h9a);
    acc(16'hff4a, 8'h00, 1'b0, 1'b0, 8'h00);
    acc(`PLWD_ADDR_RESTART, 8'hac, 1'b1, 1'b0, 8'h00);
    acc(`PLWD_ADDR_MODE, 8'h60, 1'b1, 1'b0, 8'h00);
    repeat (1000) @(negedge clock_i);
    // Thirty gated and five tickless cycles stretch the 2^11 interval; the rest must not
    rst_q.push_back(cyc + 1 + 2048 + 35);
    acc(`PLWD_ADDR_RESTART, 8'hac, 1'b1, 1'b0, 8'h00);
    acc(`PLWD_ADDR_MODE, 8'h00, 1'b0, 1'b0, 8'h60);
    acc(`PLWD_ADDR_RESTART, 8'h00, 1'b0, 1'b0, 8'h9a);
    hold(6'h01, 10);
    hold(6'h02, 10);
    hold(6'h30, 10);
    hold(6'h10, 10);
    hold(6'h20, 10);
    hold(6'h0c, 10);
    drop(2'h1, 5);
    drop(2'h2, 5);
    wait_rst();
    cause_clr_i = 1'b1;
    @(negedge clock_i);
    cause_clr_i = 1'b0;
    @(negedge clock_i);
    chk("reset_cause_o cleared", 8'h00, reset_cause_o);
    acc(`PLWD_ADDR_MODE, 8'h00, 1'b0, 1'b0, 8'h67);
    rst_q.push_back(cyc + 1 + 8192 + 45);
    acc(`PLWD_ADDR_MODE, 8'h68, 1'b1, 1'b0, 8'h00);
    hold(6'h04, 10);
    hold(6'h08, 10);
    hold(6'h01, 10);
    hold(6'h02, 10);
    hold(6'h30, 10);
    drop(2'h2, 5);
    drop(2'h1, 5);
    wait_rst();
    acc(`PLWD_ADDR_MODE, 8'h61, 1'b1, 1'b0, 8'h00);
    rst_q.push_back(cyc + 1);
    acc(`PLWD_ADDR_MODE, 8'h61, 1'b1, 1'b0, 8'h00);
    r = $random(seed);
    if (r[7:0] == `PLWD_RESTART_KEY)
      r = r ^ 32'h1;
    rst_q.push_back(cyc + 1);
    acc(`PLWD_ADDR_RESTART, r[7:0], 1'b1, 1'b0, 8'h00);
    rst_q.push_back(cyc + 1);
    acc(`PLWD_ADDR_RESTART, 8'hac, 1'b1, 1'b1, 8'h00);
    wait_rst();
    // Stopped: none of the misuses below may reset, and no overflow comes
    acc(`PLWD_ADDR_MODE, 8'h70, 1'b1, 1'b0, 8'h00);
    acc(`PLWD_ADDR_MODE, 8'h68, 1'b1, 1'b0, 8'h00);
    acc(`PLWD_ADDR_RESTART, r[7:0], 1'b1, 1'b0, 8'h00);
    acc(`PLWD_ADDR_RESTART, 8'hac, 1'b1, 1'b1, 8'h00);
    acc(`PLWD_ADDR_MODE, 8'h00, 1'b0, 1'b0, 8'h70);
    repeat (3000) @(negedge clock_i);
    do_reset(1'b1);
    rst_q.push_back(cyc + 1 + 2048);
    acc(`PLWD_ADDR_MODE, 8'h70, 1'b1, 1'b0, 8'h00);
    acc(`PLWD_ADDR_MODE, 8'h00, 1'b0, 1'b0, 8'h60);
    hold(6'h3f, 10);
    wait_rst();
    end_of_test();
  end

  initial
  begin
    repeat (60000) @(posedge clock_i);
    failures++;
    end_of_test();
  end
endmodule

`default_nettype wire
